// *** hdl/input_select_output_mode_ctrl.sv ***
`timescale 1ns/10ps
// Contract
// RULE1: Free-run routes crystal into input two path
// RULE2: Output-force-on drives outputs despite squelch
// RULE3: Bypass passes selected input straight to outputs
// RULE4: Software bypasses only in hold or precalibration
// RULE5: Software never bypasses with CMOS outputs
// RULE6: Second-choice field names auto second input
// RULE7: First-choice field names auto preferred input
// RULE8: Bandwidth code takes effect after calibration
// RULE9: Manual register field selects input without pin
// RULE10: Pin flag set: select pin picks input
// RULE11: Force-hold enters digital hold, overriding all
// RULE12: Calibration squelch disables outputs during calibration
// RULE13: Method codes: manual, non-revertive, revertive, reserved
// RULE14: Five-bit history delay for hold history
// RULE15: Register 0 resets to 0001 0100
// RULE16: Register 1 resets to 1110 0100
// RULE17: Register 2 resets to 0100 0010
// RULE18: Register 3 resets to 0000 0101
// RULE19: Register 4 resets to 0001 0010
// RULE20: Squelched outputs wait for locked calibration
// RULE21: Reserved bits fixed; reserved codes ignored
module input_select_output_mode_ctrl
    import clk_ctrl_pkg::*;
(
    input wire logic clk_i,                     // Internal device clock
    input wire logic rst_n_i,                   // Synchronous reset, active low
    input wire logic ce_i,                      // Clock enable, freezes all state
    input wire logic cfg_wr_i,                  // Register write strobe
    input wire logic cfg_rd_i,                  // Register read strobe
    input wire logic [7:0] cfg_addr_i,          // Register index
    input wire logic [7:0] cfg_wdata_i,         // Write data
    output logic [7:0] cfg_rdata_o,             // Read data, valid with cfg_rvalid_o
    output logic cfg_rvalid_o,                  // Read answer pulse
    input wire logic pin_select_flag_i,         // Manual choice comes from the pin
    input wire logic input_select_pin_i,        // External input select pin
    input wire logic clock_input_one_ok_i,      // Input one qualified
    input wire logic clock_input_two_ok_i,      // Input two qualified
    input wire logic crystal_reference_ok_i,    // Crystal reference qualified
    input wire logic calib_busy_i,              // Internal calibration in progress
    input wire logic lock_lost_i,               // Loop out of lock
    output logic free_run_route_o,              // Crystal feeds input two path
    output logic pll_bypass_o,                  // Selected input drives outputs directly
    output logic [1:0] active_input_o,          // 00 input one, 01 input two
    output logic holdover_o,                    // Digital hold active
    output logic output_enable_o,               // Output clocks running
    output logic [3:0] loop_bw_code_o,          // Bandwidth code in force
    output logic bw_calib_needed_o,             // New bandwidth waits for calibration
    output logic [1:0] selection_method_o,      // Method in force
    output logic [4:0] history_delay_o          // Hold history delay code
);
    import clk_ctrl_pkg::*;

    // Register fields
    logic free_run;
    logic output_force_on;
    logic pll_bypass;
    logic [1:0] first_choice_input;
    logic [1:0] second_choice_input;
    logic [3:0] loop_bw_code;
    logic [1:0] manual_input_choice;
    logic force_holdover;
    logic calib_squelch;
    logic [1:0] selection_method;
    logic [4:0] history_delay;

    // Calibration tracking
    logic calib_busy_q;
    logic calib_start;
    logic calib_end;
    logic calib_seen;
    logic calib_good;
    logic bw_pending;

    // Derived selection terms
    logic manual_two;
    logic two_path_ok;
    logic wr_ok;
    logic next_output_enable;
    sel_state_e sel_state;
    logic [7:0] next_rdata;

    assign wr_ok = ce_i && cfg_wr_i;
    assign calib_start = calib_busy_i && !calib_busy_q;
    assign calib_end = !calib_busy_i && calib_busy_q;

    // Register 0: free-run, force-on, bypass
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            free_run <= RST_LOOP_ROUTING_CTRL[FREE_RUN_BIT]; // RULE15
            output_force_on <= RST_LOOP_ROUTING_CTRL[OUTPUT_FORCE_ON_BIT]; // RULE15
            pll_bypass <= RST_LOOP_ROUTING_CTRL[PLL_BYPASS_BIT]; // RULE15
        end else if (wr_ok && cfg_addr_i == ADDR_LOOP_ROUTING_CTRL) begin
            free_run <= cfg_wdata_i[FREE_RUN_BIT];
            output_force_on <= cfg_wdata_i[OUTPUT_FORCE_ON_BIT];
            // Bypass legality (hold or precalibration, no CMOS) is left to software
            pll_bypass <= cfg_wdata_i[PLL_BYPASS_BIT];
        end
    end

    // Register 1: priorities; a reserved code leaves the field as it was
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            first_choice_input <= RST_INPUT_PRIORITY[FIRST_CHOICE_LSB +: 2]; // RULE16
            second_choice_input <= RST_INPUT_PRIORITY[SECOND_CHOICE_LSB +: 2]; // RULE16
        end else if (wr_ok && cfg_addr_i == ADDR_INPUT_PRIORITY) begin
            if (!cfg_wdata_i[FIRST_CHOICE_LSB + 1]) begin
                first_choice_input <= cfg_wdata_i[FIRST_CHOICE_LSB +: 2]; // RULE21
            end
            if (!cfg_wdata_i[SECOND_CHOICE_LSB + 1]) begin
                second_choice_input <= cfg_wdata_i[SECOND_CHOICE_LSB +: 2]; // RULE21
            end
        end
    end

    // Register 2: bandwidth code as written, not yet in force
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            loop_bw_code <= RST_LOOP_BANDWIDTH[LOOP_BW_LSB +: 4]; // RULE17
        end else if (wr_ok && cfg_addr_i == ADDR_LOOP_BANDWIDTH) begin
            loop_bw_code <= cfg_wdata_i[LOOP_BW_LSB +: 4];
        end
    end

    // Register 3: manual choice, forced hold, calibration squelch
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            manual_input_choice <= RST_MANUAL_SELECT_HOLD[MANUAL_CHOICE_LSB +: 2]; // RULE18
            force_holdover <= RST_MANUAL_SELECT_HOLD[FORCE_HOLDOVER_BIT]; // RULE18
            calib_squelch <= RST_MANUAL_SELECT_HOLD[CALIB_SQUELCH_BIT]; // RULE18
        end else if (wr_ok && cfg_addr_i == ADDR_MANUAL_SELECT_HOLD) begin
            if (!cfg_wdata_i[MANUAL_CHOICE_LSB + 1]) begin
                manual_input_choice <= cfg_wdata_i[MANUAL_CHOICE_LSB +: 2]; // RULE21
            end
            force_holdover <= cfg_wdata_i[FORCE_HOLDOVER_BIT];
            calib_squelch <= cfg_wdata_i[CALIB_SQUELCH_BIT];
        end
    end

    // Register 4: method (reserved code ignored) and history delay
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            selection_method <= RST_SELECT_METHOD_HISTORY[SELECTION_METHOD_LSB +: 2]; // RULE19
            history_delay <= RST_SELECT_METHOD_HISTORY[HISTORY_DELAY_LSB +: 5]; // RULE19
        end else if (wr_ok && cfg_addr_i == ADDR_SELECT_METHOD_HISTORY) begin
            if (cfg_wdata_i[SELECTION_METHOD_LSB +: 2] != 2'h3) begin
                selection_method <= cfg_wdata_i[SELECTION_METHOD_LSB +: 2]; // RULE21
            end
            history_delay <= cfg_wdata_i[HISTORY_DELAY_LSB +: 5]; // RULE14
        end
    end

    // Read mux; reserved bits always show their power-on value
    always_comb begin
        next_rdata = 8'h00;
        unique case (cfg_addr_i)
            ADDR_LOOP_ROUTING_CTRL: begin
                next_rdata = RST_LOOP_ROUTING_CTRL & ~WMASK_LOOP_ROUTING_CTRL; // RULE21
                next_rdata[FREE_RUN_BIT] = free_run;
                next_rdata[OUTPUT_FORCE_ON_BIT] = output_force_on;
                next_rdata[PLL_BYPASS_BIT] = pll_bypass;
            end
            ADDR_INPUT_PRIORITY: begin
                next_rdata = RST_INPUT_PRIORITY & ~WMASK_INPUT_PRIORITY; // RULE21
                next_rdata[FIRST_CHOICE_LSB +: 2] = first_choice_input;
                next_rdata[SECOND_CHOICE_LSB +: 2] = second_choice_input;
            end
            ADDR_LOOP_BANDWIDTH: begin
                next_rdata = RST_LOOP_BANDWIDTH & ~WMASK_LOOP_BANDWIDTH; // RULE21
                next_rdata[LOOP_BW_LSB +: 4] = loop_bw_code;
            end
            ADDR_MANUAL_SELECT_HOLD: begin
                next_rdata = RST_MANUAL_SELECT_HOLD & ~WMASK_MANUAL_SELECT_HOLD; // RULE21
                next_rdata[MANUAL_CHOICE_LSB +: 2] = manual_input_choice;
                next_rdata[FORCE_HOLDOVER_BIT] = force_holdover;
                next_rdata[CALIB_SQUELCH_BIT] = calib_squelch;
            end
            ADDR_SELECT_METHOD_HISTORY: begin
                next_rdata = RST_SELECT_METHOD_HISTORY & ~WMASK_SELECT_METHOD_HISTORY; // RULE21
                next_rdata[SELECTION_METHOD_LSB +: 2] = selection_method;
                next_rdata[HISTORY_DELAY_LSB +: 5] = history_delay;
            end
            default: next_rdata = 8'h00; // Unmapped index reads zero
        endcase
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_rdata_o <= 8'h00;
            cfg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            cfg_rvalid_o <= cfg_rd_i;
            if (cfg_rd_i) begin
                cfg_rdata_o <= next_rdata;
            end
        end
    end

    // Calibration history: busy edge tracking, first finished pass and first lock after it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            calib_busy_q <= 1'b0;
            calib_seen <= 1'b0;
            calib_good <= 1'b0;
        end else if (ce_i) begin
            calib_busy_q <= calib_busy_i;
            if (calib_end) begin
                calib_seen <= 1'b1;
            end
            // Lock counts only once a calibration has finished
            if ((calib_seen || calib_end) && !calib_busy_i && !lock_lost_i) begin
                calib_good <= 1'b1; // RULE20
            end
        end
    end

    // Bandwidth code moves into force only when a calibration starts
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            loop_bw_code_o <= RST_LOOP_BANDWIDTH[LOOP_BW_LSB +: 4];
            bw_pending <= 1'b0;
        end else if (ce_i) begin
            if (calib_start) begin
                loop_bw_code_o <= loop_bw_code; // RULE8
            end
            // A write in the start cycle still wins, so it is not lost
            if (cfg_wr_i && cfg_addr_i == ADDR_LOOP_BANDWIDTH) begin
                bw_pending <= 1'b1; // RULE8
            end else if (calib_start) begin
                bw_pending <= 1'b0;
            end
        end
    end

    // Manual source: pin when flagged, else register field
    assign manual_two = pin_select_flag_i ? input_select_pin_i // RULE10
        : (manual_input_choice == CHOICE_INPUT_TWO); // RULE9
    // Free-run puts the crystal on the second path, so its quality counts there
    assign two_path_ok = free_run ? crystal_reference_ok_i : clock_input_two_ok_i; // RULE1

    input_chooser u_chooser (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .selection_method_i(selection_method),
        .manual_two_i(manual_two),
        .first_two_i(first_choice_input == CHOICE_INPUT_TWO),
        .second_two_i(second_choice_input == CHOICE_INPUT_TWO),
        .force_holdover_i(force_holdover),
        .one_ok_i(clock_input_one_ok_i),
        .two_ok_i(two_path_ok),
        .state_o(sel_state)
    );

    // Output gating: before any calibration the frequency is untrustworthy
    always_comb begin
        if (output_force_on) begin
            next_output_enable = 1'b1; // RULE2
        end else if (calib_squelch) begin
            next_output_enable = calib_good && !calib_busy_i; // RULE12
        end else begin
            next_output_enable = calib_seen; // RULE2
        end
    end

    // Registered control outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            free_run_route_o <= 1'b0;
            pll_bypass_o <= 1'b0;
            active_input_o <= CHOICE_INPUT_ONE;
            holdover_o <= 1'b0;
            output_enable_o <= 1'b0;
            bw_calib_needed_o <= 1'b0;
            selection_method_o <= METHOD_MANUAL;
            history_delay_o <= 5'h00;
        end else if (ce_i) begin
            free_run_route_o <= free_run; // RULE1
            pll_bypass_o <= pll_bypass; // RULE3
            active_input_o <= (sel_state == SEL_TWO) ? CHOICE_INPUT_TWO : CHOICE_INPUT_ONE;
            holdover_o <= (sel_state == SEL_HOLD); // RULE11
            output_enable_o <= next_output_enable;
            bw_calib_needed_o <= bw_pending;
            selection_method_o <= selection_method; // RULE13
            history_delay_o <= history_delay; // RULE14
        end
    end

    property p_free_run;
        @(posedge clk_i) disable iff (!rst_n_i) ce_i |=> free_run_route_o == $past(free_run);
    endproperty
    a_free_run: assert property (p_free_run) else $error("free-run routing wrong"); // RULE1

    property p_bypass;
        @(posedge clk_i) disable iff (!rst_n_i) ce_i |=> pll_bypass_o == $past(pll_bypass);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass output wrong"); // RULE3

    property p_force_on;
        @(posedge clk_i) disable iff (!rst_n_i) ce_i && output_force_on |=> output_enable_o;
    endproperty
    a_force_on: assert property (p_force_on) else $error("forced output not on"); // RULE2

    property p_squelch_cal;
        @(posedge clk_i) disable iff (!rst_n_i)
            ce_i && !output_force_on && calib_squelch && calib_busy_i |=> !output_enable_o;
    endproperty
    a_squelch_cal: assert property (p_squelch_cal) else $error("output on during calibration"); // RULE12

    property p_no_lock;
        @(posedge clk_i) disable iff (!rst_n_i)
            ce_i && !output_force_on && calib_squelch && !calib_good |=> !output_enable_o;
    endproperty
    a_no_lock: assert property (p_no_lock) else $error("output on before locked calibration"); // RULE20

    sequence s_hold_request;
        ce_i && force_holdover ##1 ce_i;
    endsequence

    property p_hold_out;
        @(posedge clk_i) disable iff (!rst_n_i) s_hold_request |=> holdover_o;
    endproperty
    a_hold_out: assert property (p_hold_out) else $error("hold not shown"); // RULE11

    property p_bw_defer;
        @(posedge clk_i) disable iff (!rst_n_i) !(ce_i && calib_start) |=> $stable(loop_bw_code_o);
    endproperty
    a_bw_defer: assert property (p_bw_defer) else $error("bandwidth changed without calibration"); // RULE8

    sequence s_pin_manual;
        ce_i && !force_holdover && selection_method == METHOD_MANUAL && pin_select_flag_i
        ##1 ce_i;
    endsequence

    property p_pin_select;
        @(posedge clk_i) disable iff (!rst_n_i)
            s_pin_manual |=> active_input_o == {1'b0, $past(input_select_pin_i, 2)};
    endproperty
    a_pin_select: assert property (p_pin_select) else $error("pin choice not followed"); // RULE10

    property p_reg0_fixed;
        @(posedge clk_i) disable iff (!rst_n_i)
            ce_i && cfg_rd_i && cfg_addr_i == ADDR_LOOP_ROUTING_CTRL
            |=> cfg_rvalid_o && (cfg_rdata_o & ~WMASK_LOOP_ROUTING_CTRL)
            == (RST_LOOP_ROUTING_CTRL & ~WMASK_LOOP_ROUTING_CTRL);
    endproperty
    a_reg0_fixed: assert property (p_reg0_fixed) else $error("reserved bits changed"); // RULE21

endmodule : input_select_output_mode_ctrl

// *** hdl/clk_ctrl_pkg.sv ***
package clk_ctrl_pkg;

    // Register indices on the configuration port
    localparam logic [7:0] ADDR_LOOP_ROUTING_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INPUT_PRIORITY = 8'h01;
    localparam logic [7:0] ADDR_LOOP_BANDWIDTH = 8'h02;
    localparam logic [7:0] ADDR_MANUAL_SELECT_HOLD = 8'h03;
    localparam logic [7:0] ADDR_SELECT_METHOD_HISTORY = 8'h04;

    // Power-on values, reserved bits included
    localparam logic [7:0] RST_LOOP_ROUTING_CTRL = 8'h14;
    localparam logic [7:0] RST_INPUT_PRIORITY = 8'hE4;
    localparam logic [7:0] RST_LOOP_BANDWIDTH = 8'h42;
    localparam logic [7:0] RST_MANUAL_SELECT_HOLD = 8'h05;
    localparam logic [7:0] RST_SELECT_METHOD_HISTORY = 8'h12;

    // Writable bits per register; the rest read back their power-on value
    localparam logic [7:0] WMASK_LOOP_ROUTING_CTRL = 8'h62;
    localparam logic [7:0] WMASK_INPUT_PRIORITY = 8'h0F;
    localparam logic [7:0] WMASK_LOOP_BANDWIDTH = 8'hF0;
    localparam logic [7:0] WMASK_MANUAL_SELECT_HOLD = 8'hF0;
    localparam logic [7:0] WMASK_SELECT_METHOD_HISTORY = 8'hDF;

    // Field positions
    localparam int FREE_RUN_BIT = 6;
    localparam int OUTPUT_FORCE_ON_BIT = 5;
    localparam int PLL_BYPASS_BIT = 1;
    localparam int SECOND_CHOICE_LSB = 2;
    localparam int FIRST_CHOICE_LSB = 0;
    localparam int LOOP_BW_LSB = 4;
    localparam int MANUAL_CHOICE_LSB = 6;
    localparam int FORCE_HOLDOVER_BIT = 5;
    localparam int CALIB_SQUELCH_BIT = 4;
    localparam int SELECTION_METHOD_LSB = 6;
    localparam int HISTORY_DELAY_LSB = 0;

    // Input codes used by priority and manual choice fields
    localparam logic [1:0] CHOICE_INPUT_ONE = 2'h0;
    localparam logic [1:0] CHOICE_INPUT_TWO = 2'h1;

    // Selection method codes
    localparam logic [1:0] METHOD_MANUAL = 2'h0;
    localparam logic [1:0] METHOD_AUTO_NON_REVERT = 2'h1;
    localparam logic [1:0] METHOD_AUTO_REVERT = 2'h2;

    // Selector states
    typedef enum logic [2:0] {
        SEL_ONE = 3'b001,
        SEL_TWO = 3'b010,
        SEL_HOLD = 3'b100
    } sel_state_e;

endpackage : clk_ctrl_pkg

// *** hdl/input_chooser.sv ***
`timescale 1ns/10ps
module input_chooser
    import clk_ctrl_pkg::*;
(
    input wire logic clk_i,                 // Device clock
    input wire logic rst_n_i,               // Synchronous reset, active low
    input wire logic ce_i,                  // Clock enable
    input wire logic [1:0] selection_method_i, // Manual or automatic method
    input wire logic manual_two_i,          // Resolved manual choice is input two
    input wire logic first_two_i,           // First choice is input two
    input wire logic second_two_i,          // Second choice is input two
    input wire logic force_holdover_i,      // Force digital hold
    input wire logic one_ok_i,              // Input one usable
    input wire logic two_ok_i,              // Input two usable
    output clk_ctrl_pkg::sel_state_e state_o // Current selection
);
    import clk_ctrl_pkg::*;

    sel_state_e state;
    sel_state_e next_state;
    logic first_ok;
    logic second_ok;

    // Quality of the inputs named by the priority fields
    assign first_ok = first_two_i ? two_ok_i : one_ok_i;
    assign second_ok = second_two_i ? two_ok_i : one_ok_i;
    assign state_o = state;

    // Selection decision; forced hold beats every other control
    always_comb begin
        next_state = state;
        if (force_holdover_i) begin
            next_state = SEL_HOLD; // RULE11
        end else if (selection_method_i == METHOD_MANUAL) begin
            next_state = manual_two_i ? SEL_TWO : SEL_ONE; // RULE13
        end else if (selection_method_i == METHOD_AUTO_REVERT) begin
            // Always go back to the first choice once it is usable again
            if (first_ok) begin
                next_state = first_two_i ? SEL_TWO : SEL_ONE; // RULE7
            end else if (second_ok) begin
                next_state = second_two_i ? SEL_TWO : SEL_ONE; // RULE6
            end else begin
                next_state = SEL_HOLD;
            end
        end else begin
            // Non-revertive: keep a working input, switch only on failure
            unique case (state)
                SEL_ONE: next_state = one_ok_i ? SEL_ONE : (two_ok_i ? SEL_TWO : SEL_HOLD);
                SEL_TWO: next_state = two_ok_i ? SEL_TWO : (one_ok_i ? SEL_ONE : SEL_HOLD);
                SEL_HOLD: begin
                    if (first_ok) begin
                        next_state = first_two_i ? SEL_TWO : SEL_ONE; // RULE7
                    end else if (second_ok) begin
                        next_state = second_two_i ? SEL_TWO : SEL_ONE; // RULE6
                    end
                end
                default: next_state = SEL_HOLD;
            endcase
        end
    end

    // Selection state register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= SEL_ONE;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    sequence s_hold_forced;
        ce_i && force_holdover_i;
    endsequence

    property p_force_hold;
        @(posedge clk_i) disable iff (!rst_n_i) s_hold_forced |=> state == SEL_HOLD;
    endproperty
    a_force_hold: assert property (p_force_hold) else $error("forced hold not entered"); // RULE11

    property p_revert_first;
        @(posedge clk_i) disable iff (!rst_n_i)
            ce_i && !force_holdover_i && selection_method_i == METHOD_AUTO_REVERT && first_ok
            |=> state == (($past(first_two_i)) ? SEL_TWO : SEL_ONE);
    endproperty
    a_revert_first: assert property (p_revert_first) else $error("first choice not taken"); // RULE7

    property p_revert_second;
        @(posedge clk_i) disable iff (!rst_n_i)
            ce_i && !force_holdover_i && selection_method_i == METHOD_AUTO_REVERT && !first_ok
            && second_ok |=> state == (($past(second_two_i)) ? SEL_TWO : SEL_ONE);
    endproperty
    a_revert_second: assert property (p_revert_second) else $error("second choice not taken"); // RULE6

endmodule : input_chooser

// *** verif/input_select_output_mode_ctrl_tb_top.sv ***
`timescale 1ns/10ps
module input_select_output_mode_ctrl_tb_top;
    import clk_ctrl_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, calib_busy_i = 1'b0;
    logic pin_select_flag_i = 1'b0, input_select_pin_i = 1'b0;
    logic lock_lost_i = 1'b0, one_ok = 1'b1;
    logic [7:0] cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, cfg_rdata_o, a;
    logic [7:0] mdl [0:4];
    logic cfg_rvalid_o, free_run_route_o, pll_bypass_o, holdover_o;
    logic output_enable_o, bw_calib_needed_o;
    logic [1:0] active_input_o, selection_method_o;
    logic [3:0] loop_bw_code_o;
    logic [4:0] history_delay_o;
    int fail_count = 0, num_checks = 0, cyc = 0;
    // Free-running 250 MHz clock
    always #2 clk_i = ~clk_i;
    // Enable, input two and crystal quality tied on; input one quality and lock are driven
    input_select_output_mode_ctrl input_select_output_mode_ctrl_i (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .ce_i(1'b1), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
        .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
        .cfg_rvalid_o(cfg_rvalid_o), .pin_select_flag_i(pin_select_flag_i),
        .input_select_pin_i(input_select_pin_i), .clock_input_one_ok_i(one_ok),
        .clock_input_two_ok_i(1'b1), .crystal_reference_ok_i(1'b1),
        .calib_busy_i(calib_busy_i), .lock_lost_i(lock_lost_i),
        .free_run_route_o(free_run_route_o), .pll_bypass_o(pll_bypass_o),
        .active_input_o(active_input_o), .holdover_o(holdover_o),
        .output_enable_o(output_enable_o), .loop_bw_code_o(loop_bw_code_o),
        .bw_calib_needed_o(bw_calib_needed_o), .selection_method_o(selection_method_o),
        .history_delay_o(history_delay_o));
    // Expected register after a write; reserved codes keep the old field
    function automatic logic [7:0] nxt(input logic [7:0] ad, old, wd);
        logic [7:0] m;
        logic [7:0] n;
        m = (ad == 8'h00) ? WMASK_LOOP_ROUTING_CTRL : (ad == 8'h01) ? WMASK_INPUT_PRIORITY :
            (ad == 8'h02) ? WMASK_LOOP_BANDWIDTH : (ad == 8'h03) ? WMASK_MANUAL_SELECT_HOLD :
            WMASK_SELECT_METHOD_HISTORY;
        n = (old & ~m) | (wd & m);
        if (ad == 8'h01 && wd[1]) n[1:0] = old[1:0];
        if (ad == 8'h01 && wd[3]) n[3:2] = old[3:2];
        if (ad == 8'h03 && wd[7]) n[7:6] = old[7:6];
        if (ad == 8'h04 && wd[7:6] == 2'h3) n[7:6] = old[7:6];
        return n;
    endfunction : nxt
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(negedge clk_i);
    endtask : settle
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk_i);
        cfg_wr_i = 1'b1;
        cfg_addr_i = ad;
        cfg_wdata_i = d;
        @(negedge clk_i);
        cfg_wr_i = 1'b0;
        if (ad < 8'h05) mdl[ad] = nxt(ad, mdl[ad], d);
    endtask : wr
    // Read answer is checked in the one cycle that it stands
    task automatic rdc(input logic [7:0] ad);
        @(negedge clk_i);
        cfg_rd_i = 1'b1;
        cfg_addr_i = ad;
        @(negedge clk_i);
        cfg_rd_i = 1'b0;
        chk({7'h00, cfg_rvalid_o}, 8'h01);
        chk(cfg_rdata_o, (ad < 8'h05) ? mdl[ad] : 8'h00);
    endtask : rdc
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(32'h719EBF01));
        mdl = '{RST_LOOP_ROUTING_CTRL, RST_INPUT_PRIORITY, RST_LOOP_BANDWIDTH,
            RST_MANUAL_SELECT_HOLD, RST_SELECT_METHOD_HISTORY};
        settle(5);
        rst_n_i = 1'b1;
        rdc(8'h00);
        rdc(8'h01);
        rdc(8'h02);
        rdc(8'h03);
        rdc(8'h04);
        rdc(8'h07);
        $display("reset test done");
        // Random writes, unmapped index included, each read back at once
        for (int i = 0; i < 60; i++) begin
            a = 8'($urandom % 6);
            wr(a, 8'($urandom));
            rdc(a);
        end
        $display("random register test done");
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h42);
        wr(8'h03, 8'h40);
        settle(4);
        chk({6'h00, free_run_route_o, pll_bypass_o}, 8'h03);
        chk({6'h00, active_input_o}, 8'h01);
        pin_select_flag_i = 1'b1;
        settle(4);
        chk({6'h00, active_input_o}, 8'h00);
        input_select_pin_i = 1'b1;
        settle(4);
        chk({6'h00, active_input_o}, 8'h01);
        wr(8'h03, 8'h60);
        settle(4);
        chk({7'h00, holdover_o}, 8'h01);
        $display("selection test done");
        // Bandwidth waits for calibration; outputs stay off until the first one
        wr(8'h02, 8'hA0);
        settle(2);
        chk({output_enable_o, bw_calib_needed_o, 2'h0, loop_bw_code_o}, 8'h44);
        calib_busy_i = 1'b1;
        settle(3);
        calib_busy_i = 1'b0;
        settle(3);
        chk({output_enable_o, bw_calib_needed_o, 2'h0, loop_bw_code_o}, 8'h8A);
        wr(8'h03, 8'h70);
        calib_busy_i = 1'b1;
        settle(3);
        chk({7'h00, output_enable_o}, 8'h00);
        wr(8'h00, 8'h62);
        settle(2);
        chk({7'h00, output_enable_o}, 8'h01);
        calib_busy_i = 1'b0;
        $display("calibration test done");
        for (int i = 0; i < 3; i++) begin
            wr(8'h04, {2'(i), 6'h0B});
            settle(2);
            chk({selection_method_o, 1'b0, history_delay_o}, {2'(i), 6'h0B});
        end
        $display("method test done");
        // Mid-run reset: squelched outputs wait for lock after a finished calibration, even one that ended unlocked
        rst_n_i = 1'b0;
        settle(2);
        rst_n_i = 1'b1;
        wr(8'h03, 8'h10);
        lock_lost_i = 1'b1;
        calib_busy_i = 1'b1;
        settle(3);
        calib_busy_i = 1'b0;
        settle(3);
        chk({7'h00, output_enable_o}, 8'h00);
        lock_lost_i = 1'b0;
        settle(3);
        chk({7'h00, output_enable_o}, 8'h01);
        // Revertive: first choice lost, second taken, first taken back on recovery
        wr(8'h04, 8'h80);
        one_ok = 1'b0;
        settle(4);
        chk({6'h00, active_input_o}, 8'h01);
        one_ok = 1'b1;
        settle(4);
        chk({6'h00, active_input_o}, 8'h00);
        $display("lock and auto test done");
        end_of_test();
    end
endmodule : input_select_output_mode_ctrl_tb_top
